// ### core/cdd_pkg.sv
package cdd_pkg;

  // Register map of the AHB-Lite slave, byte addresses of aligned words.
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_CFG = 8'h08;
  localparam logic [7:0] ADDR_VIEW = 8'h0C;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // Execution times as printed, and their cycle counts at the system clock.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned INSTR_TIME_NS = 37000;
  localparam int unsigned LONG_TIME_NS = 1520000;
  localparam int unsigned INSTR_CYCLES = INSTR_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned LONG_CYCLES = LONG_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned BUSY_W = 20;

  // Opcode class bits: the highest set bit of the instruction byte picks the class.
  localparam int unsigned OPB_TEXT_ADDR = 7;
  localparam int unsigned OPB_GLYPH_ADDR = 6;
  localparam int unsigned OPB_FUNC = 5;
  localparam int unsigned OPB_SHIFT = 4;
  localparam int unsigned OPB_DISP = 3;
  localparam int unsigned OPB_ENTRY = 2;
  localparam int unsigned OPB_HOME = 1;
  localparam int unsigned OPB_CLEAR = 0;

  // Operand field positions inside the instruction byte.
  localparam int unsigned FUNC_DL = 4;
  localparam int unsigned FUNC_N = 3;
  localparam int unsigned FUNC_RE = 2;
  localparam int unsigned FUNC_BE = 1;
  localparam int unsigned FUNC_LP = 0;
  localparam int unsigned SHIFT_SC = 3;
  localparam int unsigned SHIFT_RL = 2;
  localparam int unsigned DISP_HI = 2;
  localparam int unsigned DISP_MID = 1;
  localparam int unsigned DISP_LO = 0;
  localparam int unsigned ENTRY_ID = 1;
  localparam int unsigned ENTRY_S = 0;

  // Scroll quantity decoding.
  localparam logic [5:0] SCROLL_MAX_DOTS = 6'h30;
  localparam logic [1:0] SCROLL_SAT_BITS = 2'b11;

  // Reset values and fill pattern.
  localparam logic RST_ENTRY_INC = 1'b1;
  localparam logic RST_BUS_WIDTH = 1'b1;
  localparam logic [7:0] BLANK_CHAR = 8'h20;
  localparam logic [6:0] AC_ZERO = 7'h00;
  localparam logic [6:0] TEXT_LAST = 7'h7F;

  // Memory depths.
  localparam int unsigned TEXT_DEPTH = 128;
  localparam int unsigned GLYPH_DEPTH = 64;
  localparam int unsigned ICON_DEPTH = 16;

  // Characters per line: panel alone, and with an extension driver (text buffer share).
  localparam logic [6:0] CPL_5DOT_WIDE = 7'h18;
  localparam logic [6:0] CPL_5DOT_FOUR = 7'h0C;
  localparam logic [6:0] CPL_6DOT_WIDE = 7'h14;
  localparam logic [6:0] CPL_6DOT_FOUR = 7'h0A;
  localparam logic [6:0] CPL_EXT_ONE = 7'h50;
  localparam logic [6:0] CPL_EXT_TWO = 7'h28;
  localparam logic [6:0] CPL_EXT_FOUR = 7'h14;
  localparam logic [5:0] FONT_5DOT = 6'h05;
  localparam logic [5:0] FONT_6DOT = 6'h06;

  typedef enum logic [1:0] {CDD_RAM_TEXT, CDD_RAM_GLYPH, CDD_RAM_ICON} cdd_ram_e;

endpackage : cdd_pkg

// ### core/cdd_decoder.sv
// Functional notes
// - Scroll dot count is written only while the extension bank is selected.
// - Scrolling lines shift left by the dot count, 1 to 48 dots.
// - Count 0 means no shift; 1..47 as is; both top bits set gives 48.
// - With expander and scrolling, characters per line drop by scroll in characters.
// - Low power mode suppresses whole display shift and horizontal scroll.
// - Busy status read returns busy flag and address counter together.
// - One address counter serves all three RAMs, set by latest instruction.
// - Data write stores a byte in selected RAM, then steps counter.
// - Data write shifts the display in entry direction when entry shift on.
// - Data read returns a byte from selected RAM; first read unset is invalid.
// - Data read steps the counter but never shifts the display.
// - Cursor shift reloads the counter like a text buffer address set.
// - Opcode 01 clears display and zeroes counter in either bank, long time.
// - Opcode 1x zeroes counter and unshifts display, text kept, long time.
// - Opcode 1xyz sets display controls in bank 0, font options in bank 1.
// - Bank 0 shift opcode moves cursor or shifts display, text kept.
// - Bank 1 shift opcode loads the four-bit line scroll mask.
// - Function set writes width, lines, bank; bank 1 adds blink, low power.
// - Bank 0 sets six-bit glyph address; bank 1 sets four-bit icon address.
// - In bank 0 the bank-one-only fields keep their stored values.
// - Shift bits choose cursor left/right or whole display left/right.
`timescale 1ns/1ns
`default_nettype none

module cdd_decoder #(
  parameter int unsigned LONG_CYCLES = cdd_pkg::LONG_CYCLES
) (
  input wire logic CLK_SYS, // System clock, 100 MHz.
  input wire logic RESETN, // Asynchronous reset, active low.
  input wire logic HSEL, // Slave select.
  input wire logic [31:0] HADDR, // Byte address.
  input wire logic [1:0] HTRANS, // Transfer type.
  input wire logic HWRITE, // Write when high.
  input wire logic [2:0] HSIZE, // Transfer size, word only.
  input wire logic [31:0] HWDATA, // Write data.
  input wire logic HREADY, // Bus ready in.
  output logic HREADYOUT, // Always ready, no wait states.
  output logic HRESP, // Always OKAY.
  output logic [31:0] HRDATA, // Read data.
  input wire logic EXPANDER_PRESENT, // Extension driver strap pin.
  output logic BUSY_FLAG, // Instruction in execution.
  output logic DISPLAY_ON, // Display enable.
  output logic CURSOR_ON, // Cursor enable.
  output logic BLINK_ON, // Cursor character blink.
  output logic SIX_DOT_WIDTH, // Six dot font width.
  output logic INVERT_CURSOR, // Inverting cursor.
  output logic FOUR_LINE_MODE, // Four line display.
  output logic TWO_LINE_MODE, // Two line display.
  output logic USER_GLYPH_BLINK, // User glyph and icon blink.
  output logic LOW_POWER_ACTIVE, // Low power in effect.
  output logic [3:0] LINE_SCROLL_MASK, // Lines taking part in scroll.
  output logic [5:0] SCROLL_SHIFT_DOTS, // Effective left scroll in dots.
  output logic [6:0] DISPLAY_SHIFT // Whole display shift, left positive.
);

  // Bus-side state.
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  // Instruction state.
  logic [cdd_pkg::BUSY_W-1:0] busy_cnt_ff;
  logic [6:0] ac_ff;
  cdd_pkg::cdd_ram_e ram_sel_ff;
  logic [6:0] shift_ff;
  logic entry_inc_ff;
  logic entry_shift_ff;
  logic disp_on_ff;
  logic cursor_on_ff;
  logic blink_on_ff;
  logic six_dot_ff;
  logic invert_ff;
  logic four_line_ff;
  logic two_line_ff;
  logic bus_width_ff;
  logic ext_bank_ff;
  logic glyph_blink_ff;
  logic low_power_ff;
  logic [3:0] scroll_mask_ff;
  logic [5:0] scroll_cnt_ff;
  logic exp_meta_ff;
  logic exp_sync_ff;
  logic clear_run_ff;
  logic [6:0] clear_idx_ff;
  logic refresh_ff;
  logic [7:0] read_latch_ff;
  logic lp_out_ff;
  logic [5:0] dots_out_ff;
  // Memories.
  logic [7:0] text_mem [cdd_pkg::TEXT_DEPTH];
  logic [7:0] glyph_mem [cdd_pkg::GLYPH_DEPTH];
  logic [7:0] icon_mem [cdd_pkg::ICON_DEPTH];
  // Combinational terms.
  logic busy;
  logic ap_valid;
  logic instr_go;
  logic data_wr_go;
  logic data_rd_go;
  logic lp_active;
  logic [7:0] op;
  logic [7:0] ram_q;
  logic [5:0] dots_decoded;
  logic [5:0] dots_eff;
  logic [6:0] cpl_base;
  logic [5:0] cpl_cut;
  logic [6:0] cpl_eff;
  logic dec_text_addr;
  logic dec_scroll;
  logic dec_glyph_addr;
  logic dec_icon_addr;
  logic dec_func;
  logic dec_shift;
  logic dec_mask;
  logic dec_disp;
  logic dec_ext;
  logic dec_entry;
  logic dec_home;
  logic dec_clear;

  // Steps the counter and wraps it inside the selected RAM's address space.
  function automatic logic [6:0] ac_step(input logic [6:0] ac, input logic up,
                                         input cdd_pkg::cdd_ram_e sel);
    logic [6:0] nxt;
    nxt = up ? 7'(ac + 7'h01) : 7'(ac - 7'h01);
    case (sel)
      cdd_pkg::CDD_RAM_GLYPH: nxt = {1'b0, nxt[5:0]};
      cdd_pkg::CDD_RAM_ICON: nxt = {3'b000, nxt[3:0]};
      default: nxt = nxt;
    endcase
    return nxt;
  endfunction : ac_step

  // The slave never stretches a transfer and never signals an error.
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_ff;
  assign ap_valid = HSEL & HREADY & HTRANS[1];
  assign op = HWDATA[7:0];
  assign busy = (busy_cnt_ff != '0);

  // Commands run from the data phase of a write; anything arriving while busy is dropped.
  assign instr_go = wr_pend_ff & (wr_addr_ff == cdd_pkg::ADDR_INSTR) & ~busy;
  assign data_wr_go = wr_pend_ff & (wr_addr_ff == cdd_pkg::ADDR_DATA) & ~busy;
  // A read in the same cycle as an executing write is not executed and never retried, so one step per cycle.
  assign data_rd_go = ap_valid & ~HWRITE & (HADDR[7:0] == cdd_pkg::ADDR_DATA) & ~busy
                      & ~instr_go & ~data_wr_go;

  // Low power only bites without an extension driver.
  assign lp_active = low_power_ff & ~exp_sync_ff;

  // The strap crosses in from a pin, so it passes two flops first.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      exp_meta_ff <= 1'b0;
      exp_sync_ff <= 1'b0;
    end else begin
      exp_meta_ff <= EXPANDER_PRESENT;
      exp_sync_ff <= exp_meta_ff;
    end
  end

  // Address phase capture; only writes need a data phase of their own here.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= ap_valid & HWRITE;
      wr_addr_ff <= HADDR[7:0];
    end
  end

  // Read data is chosen in the address phase and stands through the data phase.
  // Busy includes a write in its data phase so that a poll right behind it sees one.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      hrdata_ff <= cdd_pkg::RDATA_ZERO;
    end else if (ap_valid && !HWRITE) begin
      case (HADDR[7:0])
        cdd_pkg::ADDR_INSTR: hrdata_ff <= {24'h00_0000, busy | instr_go | data_wr_go,
                                           ac_ff};
        cdd_pkg::ADDR_DATA: hrdata_ff <= {24'h00_0000, read_latch_ff};
        cdd_pkg::ADDR_CFG: hrdata_ff <= {8'h00, scroll_cnt_ff, scroll_mask_ff,
                                         low_power_ff, glyph_blink_ff, ext_bank_ff,
                                         bus_width_ff, two_line_ff, four_line_ff,
                                         invert_ff, six_dot_ff, blink_on_ff,
                                         cursor_on_ff, disp_on_ff, entry_shift_ff,
                                         entry_inc_ff, ram_sel_ff == cdd_pkg::CDD_RAM_ICON};
        cdd_pkg::ADDR_VIEW: hrdata_ff <= {11'h000, cpl_eff, dots_eff, shift_ff, lp_active};
        default: hrdata_ff <= cdd_pkg::RDATA_ZERO;
      endcase
    end
  end

  // Instruction decode: the highest set bit names the class, the bank picks the meaning.
  always_comb begin
    dec_text_addr = 1'b0;
    dec_scroll = 1'b0;
    dec_glyph_addr = 1'b0;
    dec_icon_addr = 1'b0;
    dec_func = 1'b0;
    dec_shift = 1'b0;
    dec_mask = 1'b0;
    dec_disp = 1'b0;
    dec_ext = 1'b0;
    dec_entry = 1'b0;
    dec_home = 1'b0;
    dec_clear = 1'b0;
    if (instr_go) begin
      if (op[cdd_pkg::OPB_TEXT_ADDR]) begin
        dec_scroll = ext_bank_ff;
        dec_text_addr = ~ext_bank_ff;
      end else if (op[cdd_pkg::OPB_GLYPH_ADDR]) begin
        dec_icon_addr = ext_bank_ff;
        dec_glyph_addr = ~ext_bank_ff;
      end else if (op[cdd_pkg::OPB_FUNC]) begin
        dec_func = 1'b1;
      end else if (op[cdd_pkg::OPB_SHIFT]) begin
        dec_mask = ext_bank_ff;
        dec_shift = ~ext_bank_ff;
      end else if (op[cdd_pkg::OPB_DISP]) begin
        dec_ext = ext_bank_ff;
        dec_disp = ~ext_bank_ff;
      end else if (op[cdd_pkg::OPB_ENTRY]) begin
        dec_entry = 1'b1;
      end else if (op[cdd_pkg::OPB_HOME]) begin
        dec_home = 1'b1;
      end else if (op[cdd_pkg::OPB_CLEAR]) begin
        dec_clear = 1'b1;
      end
    end
  end

  // Busy counter: loaded at acceptance, longer for home and clear, stretched in low power
  // because the core clock is divided then (four in one-line mode, two otherwise).
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      busy_cnt_ff <= '0;
    end else if (instr_go || data_wr_go || data_rd_go) begin
      if (lp_active && !two_line_ff && !four_line_ff) begin
        busy_cnt_ff <= (dec_home || dec_clear) ? cdd_pkg::BUSY_W'(LONG_CYCLES * 4)
                       : cdd_pkg::BUSY_W'(cdd_pkg::INSTR_CYCLES * 4);
      end else if (lp_active) begin
        busy_cnt_ff <= (dec_home || dec_clear) ? cdd_pkg::BUSY_W'(LONG_CYCLES * 2)
                       : cdd_pkg::BUSY_W'(cdd_pkg::INSTR_CYCLES * 2);
      end else begin
        busy_cnt_ff <= (dec_home || dec_clear) ? cdd_pkg::BUSY_W'(LONG_CYCLES)
                       : cdd_pkg::BUSY_W'(cdd_pkg::INSTR_CYCLES);
      end
    end else if (busy) begin
      busy_cnt_ff <= busy_cnt_ff - cdd_pkg::BUSY_W'(1);
    end
  end

  // The single address counter shared by all three RAMs.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ac_ff <= cdd_pkg::AC_ZERO;
    end else if (dec_clear || dec_home) begin
      ac_ff <= cdd_pkg::AC_ZERO;
    end else if (dec_text_addr) begin
      ac_ff <= op[6:0];
    end else if (dec_glyph_addr) begin
      ac_ff <= {1'b0, op[5:0]};
    end else if (dec_icon_addr) begin
      ac_ff <= {3'b000, op[3:0]};
    end else if (dec_shift && !op[cdd_pkg::SHIFT_SC]) begin
      ac_ff <= ac_step(ac_ff, op[cdd_pkg::SHIFT_RL], cdd_pkg::CDD_RAM_TEXT);
    end else if (data_wr_go || data_rd_go) begin
      ac_ff <= ac_step(ac_ff, entry_inc_ff, ram_sel_ff);
    end
  end

  // Which RAM data accesses reach; a cursor shift counts as a text buffer address set.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ram_sel_ff <= cdd_pkg::CDD_RAM_TEXT;
    end else if (dec_clear || dec_home || dec_text_addr || (dec_shift && !op[cdd_pkg::SHIFT_SC])) begin
      ram_sel_ff <= cdd_pkg::CDD_RAM_TEXT;
    end else if (dec_glyph_addr) begin
      ram_sel_ff <= cdd_pkg::CDD_RAM_GLYPH;
    end else if (dec_icon_addr) begin
      ram_sel_ff <= cdd_pkg::CDD_RAM_ICON;
    end
  end

  // Whole display shift offset; the cursor rides along because the counter is untouched.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      shift_ff <= 7'h00;
    end else if (dec_clear || dec_home) begin
      shift_ff <= 7'h00;
    end else if (dec_shift && op[cdd_pkg::SHIFT_SC] && !lp_active) begin
      shift_ff <= op[cdd_pkg::SHIFT_RL] ? 7'(shift_ff - 7'h01) : 7'(shift_ff + 7'h01);
    end else if (data_wr_go && entry_shift_ff && !lp_active) begin
      shift_ff <= entry_inc_ff ? 7'(shift_ff + 7'h01) : 7'(shift_ff - 7'h01);
    end
  end

  // Entry mode; clear also restores increment as the home direction.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      entry_inc_ff <= cdd_pkg::RST_ENTRY_INC;
      entry_shift_ff <= 1'b0;
    end else if (dec_entry) begin
      entry_inc_ff <= op[cdd_pkg::ENTRY_ID];
      entry_shift_ff <= op[cdd_pkg::ENTRY_S];
    end else if (dec_clear) begin
      entry_inc_ff <= cdd_pkg::RST_ENTRY_INC;
    end
  end

  // Display controls and the bank-one font options; each only moves on its own opcode.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      disp_on_ff <= 1'b0;
      cursor_on_ff <= 1'b0;
      blink_on_ff <= 1'b0;
      six_dot_ff <= 1'b0;
      invert_ff <= 1'b0;
      four_line_ff <= 1'b0;
    end else if (dec_disp) begin
      disp_on_ff <= op[cdd_pkg::DISP_HI];
      cursor_on_ff <= op[cdd_pkg::DISP_MID];
      blink_on_ff <= op[cdd_pkg::DISP_LO];
    end else if (dec_ext) begin
      six_dot_ff <= op[cdd_pkg::DISP_HI];
      invert_ff <= op[cdd_pkg::DISP_MID];
      four_line_ff <= op[cdd_pkg::DISP_LO];
    end
  end

  // Function set: width, lines and bank always; blink and low power only from bank 1.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      bus_width_ff <= cdd_pkg::RST_BUS_WIDTH;
      two_line_ff <= 1'b0;
      ext_bank_ff <= 1'b0;
      glyph_blink_ff <= 1'b0;
      low_power_ff <= 1'b0;
    end else if (dec_func) begin
      bus_width_ff <= op[cdd_pkg::FUNC_DL];
      two_line_ff <= op[cdd_pkg::FUNC_N];
      ext_bank_ff <= op[cdd_pkg::FUNC_RE];
      if (ext_bank_ff) begin
        glyph_blink_ff <= op[cdd_pkg::FUNC_BE];
        low_power_ff <= op[cdd_pkg::FUNC_LP];
      end
    end
  end

  // Scroll mask and dot count, both written only from bank 1.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      scroll_mask_ff <= 4'h0;
      scroll_cnt_ff <= 6'h00;
    end else if (dec_mask) begin
      scroll_mask_ff <= op[3:0];
    end else if (dec_scroll) begin
      scroll_cnt_ff <= op[5:0];
    end
  end

  // Dot count decode; anything with both top bits set saturates at the maximum.
  assign dots_decoded = (scroll_cnt_ff[5:4] == cdd_pkg::SCROLL_SAT_BITS)
                        ? cdd_pkg::SCROLL_MAX_DOTS : scroll_cnt_ff;
  assign dots_eff = lp_active ? 6'h00 : dots_decoded;

  // Characters per line; with an expander the scroll eats whole characters of the line.
  always_comb begin
    if (exp_sync_ff) begin
      cpl_base = four_line_ff ? cdd_pkg::CPL_EXT_FOUR
                 : (two_line_ff ? cdd_pkg::CPL_EXT_TWO : cdd_pkg::CPL_EXT_ONE);
      cpl_cut = (scroll_mask_ff != 4'h0)
                ? 6'(dots_eff / (six_dot_ff ? cdd_pkg::FONT_6DOT : cdd_pkg::FONT_5DOT))
                : 6'h00;
    end else begin
      cpl_base = six_dot_ff ? (four_line_ff ? cdd_pkg::CPL_6DOT_FOUR : cdd_pkg::CPL_6DOT_WIDE)
                 : (four_line_ff ? cdd_pkg::CPL_5DOT_FOUR : cdd_pkg::CPL_5DOT_WIDE);
      cpl_cut = 6'h00;
    end
    cpl_eff = (cpl_base > {1'b0, cpl_cut}) ? 7'(cpl_base - {1'b0, cpl_cut}) : 7'h00;
  end

  // Clear walks the whole text buffer with blanks while busy covers it.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      clear_run_ff <= 1'b0;
      clear_idx_ff <= cdd_pkg::AC_ZERO;
    end else if (dec_clear) begin
      clear_run_ff <= 1'b1;
      clear_idx_ff <= cdd_pkg::AC_ZERO;
    end else if (clear_run_ff) begin
      clear_run_ff <= (clear_idx_ff != cdd_pkg::TEXT_LAST);
      clear_idx_ff <= 7'(clear_idx_ff + 7'h01);
    end
  end

  // Memory writes; the arrays carry no reset, as real RAM would.
  always_ff @(posedge CLK_SYS) begin
    if (clear_run_ff) begin
      text_mem[clear_idx_ff] <= cdd_pkg::BLANK_CHAR;
    end else if (data_wr_go && ram_sel_ff == cdd_pkg::CDD_RAM_TEXT) begin
      text_mem[ac_ff] <= op;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (data_wr_go && ram_sel_ff == cdd_pkg::CDD_RAM_GLYPH) begin
      glyph_mem[ac_ff[5:0]] <= op;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (data_wr_go && ram_sel_ff == cdd_pkg::CDD_RAM_ICON) begin
      icon_mem[ac_ff[3:0]] <= op;
    end
  end

  // RAM output at the counter, selected by the last address set.
  always_comb begin
    case (ram_sel_ff)
      cdd_pkg::CDD_RAM_GLYPH: ram_q = glyph_mem[ac_ff[5:0]];
      cdd_pkg::CDD_RAM_ICON: ram_q = icon_mem[ac_ff[3:0]];
      default: ram_q = text_mem[ac_ff];
    endcase
  end

  // The read latch prefetches after address sets, cursor moves and reads, but not after
  // writes, so a read straight after a write returns stale data until the host re-aims.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      refresh_ff <= 1'b0;
    end else begin
      refresh_ff <= dec_text_addr | dec_glyph_addr | dec_icon_addr | dec_home | dec_clear
                    | (dec_shift & ~op[cdd_pkg::SHIFT_SC]) | data_rd_go;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      read_latch_ff <= 8'h00;
    end else if (refresh_ff) begin
      read_latch_ff <= ram_q;
    end
  end

  // Registered copies of derived levels for the display side.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      lp_out_ff <= 1'b0;
      dots_out_ff <= 6'h00;
    end else begin
      lp_out_ff <= lp_active;
      dots_out_ff <= dots_eff;
    end
  end

  // Output drive.
  assign BUSY_FLAG = busy;
  assign DISPLAY_ON = disp_on_ff;
  assign CURSOR_ON = cursor_on_ff;
  assign BLINK_ON = blink_on_ff;
  assign SIX_DOT_WIDTH = six_dot_ff;
  assign INVERT_CURSOR = invert_ff;
  assign FOUR_LINE_MODE = four_line_ff;
  assign TWO_LINE_MODE = two_line_ff;
  assign USER_GLYPH_BLINK = glyph_blink_ff;
  assign LOW_POWER_ACTIVE = lp_out_ff;
  assign LINE_SCROLL_MASK = scroll_mask_ff;
  assign SCROLL_SHIFT_DOTS = dots_out_ff;
  assign DISPLAY_SHIFT = shift_ff;

endmodule : cdd_decoder

`default_nettype wire

// ### sim/cdd_decoder_props.sv
`timescale 1ns/1ns
`default_nettype none
module cdd_props (
  input wire logic CLK_SYS, // Clock.
  input wire logic RESETN, // Reset.
  input wire logic HSEL, // Select.
  input wire logic [31:0] HADDR, // Address.
  input wire logic [1:0] HTRANS, // Type.
  input wire logic HWRITE, // Write.
  input wire logic HREADY, // Ready in.
  input wire logic HREADYOUT, // Ready out.
  input wire logic HRESP, // Response.
  input wire logic [31:0] HWDATA, // Write data.
  input wire logic [31:0] HRDATA, // Read data.
  input wire logic BUSY_FLAG, // Busy.
  input wire logic DISPLAY_ON, // Display on.
  input wire logic [3:0] LINE_SCROLL_MASK, // Scroll mask.
  input wire logic LOW_POWER_ACTIVE, // Low power.
  input wire logic [5:0] SCROLL_SHIFT_DOTS // Scroll dots.
);
  // Address phases taken by the slave, and those aimed at the instruction word.
  wire logic ap = HSEL && HREADY && HTRANS[1];
  wire logic ap_ins = ap && (HADDR[7:0] == cdd_pkg::ADDR_INSTR);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  AST_READY: assert property (HREADYOUT && !HRESP) else $error("slave stalled");
  AST_BUSY_START: assert property (ap_ins && HWRITE && !BUSY_FLAG ##1 HWDATA[7:0] != 8'h00
    |=> BUSY_FLAG) else $error("busy did not start");
  AST_BUSY_HOLD: assert property ($rose(BUSY_FLAG) |-> BUSY_FLAG[*8]) else $error("busy short");
  // The status bit is taken in the address phase, so busy may end or start across it.
  AST_STATUS: assert property (ap_ins && !HWRITE |=> HRDATA[31:8] == 24'h00_0000
    && HRDATA[7] == ($past(BUSY_FLAG) || BUSY_FLAG)) else $error("status word wrong");
  AST_RDATA_HOLD: assert property (!$past(ap && !HWRITE) |-> $stable(HRDATA))
    else $error("read data moved");
  AST_SCROLL_MAX: assert property (SCROLL_SHIFT_DOTS <= cdd_pkg::SCROLL_MAX_DOTS)
    else $error("scroll over range");
  AST_LP_SCROLL: assert property (LOW_POWER_ACTIVE |-> SCROLL_SHIFT_DOTS == 6'h00)
    else $error("scroll in low power");
  AST_CFG_EXEC: assert property ($changed({DISPLAY_ON, LINE_SCROLL_MASK}) |-> $rose(BUSY_FLAG))
    else $error("control changed off execution");
  // Main scenarios reached.
  cover property ($rose(BUSY_FLAG));
  cover property (LOW_POWER_ACTIVE);
  cover property (SCROLL_SHIFT_DOTS == 6'h30);
endmodule : cdd_props
bind cdd_decoder cdd_props cdd_props_u (.*);
`default_nettype wire

// ### sim/cdd_host.sv
`timescale 1ns/1ns
`default_nettype none
module cdd_host (
  input wire logic CLK_SYS, // Clock.
  input wire logic HREADY, // Bus ready.
  input wire logic [31:0] HRDATA, // Read data.
  output logic HSEL, // Select.
  output logic [31:0] HADDR, // Address.
  output logic [1:0] HTRANS, // Type.
  output logic HWRITE, // Write.
  output logic [2:0] HSIZE, // Size.
  output logic [31:0] HWDATA // Write data.
);
  // Only whole words to one slave, so select and size never move.
  assign HSEL = 1'b1;
  assign HSIZE = 3'h2;
  initial begin
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HADDR = 32'h0000_0000;
    HWDATA = 32'h0000_0000;
  end
  // One transfer; released write data is inverted so a stale value is never mistaken.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                      output logic [31:0] q);
    @(posedge CLK_SYS);
    HADDR <= {24'h00_0000, a};
    HWRITE <= w;
    HTRANS <= 2'h2;
    do @(posedge CLK_SYS); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= {24'h00_0000, d};
    do @(posedge CLK_SYS); while (HREADY !== 1'b1);
    q = HRDATA;
    HWDATA <= ~HWDATA;
  endtask : xfer
  // The device drops accesses while busy, so poll until the flag reads zero.
  task automatic op(input logic [7:0] a, input logic w, input logic [7:0] d,
                    output logic [31:0] q);
    q = 32'h0000_0080;
    while (q[7] !== 1'b0) xfer(cdd_pkg::ADDR_INSTR, 1'b0, 8'h00, q);
    xfer(a, w, d, q);
  endtask : op
endmodule : cdd_host
`default_nettype wire

// ### sim/test_char_display_instruction_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module test_char_display_instruction_decoder;
  logic CLK_SYS = 1'b0;
  logic RESETN = 1'b0;
  logic EXPANDER_PRESENT = 1'b0;
  logic HSEL, HWRITE, HREADYOUT, HRESP, BUSY_FLAG, DISPLAY_ON, CURSOR_ON, BLINK_ON;
  logic SIX_DOT_WIDTH, INVERT_CURSOR, FOUR_LINE_MODE, TWO_LINE_MODE, USER_GLYPH_BLINK;
  logic LOW_POWER_ACTIVE;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [3:0] LINE_SCROLL_MASK;
  logic [5:0] SCROLL_SHIFT_DOTS;
  logic [6:0] DISPLAY_SHIFT;
  logic [31:0] HADDR, HWDATA, HRDATA, q;
  wire logic HREADY = HREADYOUT;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  cdd_host host_u (.*);
  // A short clear time keeps the run brief.
  cdd_decoder #(.LONG_CYCLES(300)) dut_u (.*);
  always #5 CLK_SYS = ~CLK_SYS;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // Some outputs land a cycle after execution, so look two falling edges on.
  task automatic ins(input logic [7:0] d);
    host_u.op(cdd_pkg::ADDR_INSTR, 1'b1, d, q);
    repeat (2) @(negedge CLK_SYS);
  endtask : ins
  // A hang is cut short well beyond sixteen instruction times.
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    @(negedge CLK_SYS);
    chk("busy after reset", BUSY_FLAG, 32'h0000_0000);
    ins(8'h34);
    ins(8'hBF);
    chk("saturated dots", SCROLL_SHIFT_DOTS, 32'h0000_0030);
    ins(8'h85);
    chk("scroll dots", SCROLL_SHIFT_DOTS, 32'h0000_0005);
    ins(8'h1A);
    chk("scroll mask", LINE_SCROLL_MASK, 32'h0000_000A);
    $display("test extension bank done");
    ins(8'h30);
    ins(8'h18);
    chk("display shift", DISPLAY_SHIFT, 32'h0000_0001);
    ins(8'h02);
    chk("shift restored", DISPLAY_SHIFT, 32'h0000_0000);
    ins(8'h8F);
    chk("dots kept", SCROLL_SHIFT_DOTS, 32'h0000_0005);
    ins(8'h0F);
    chk("display controls", {DISPLAY_ON, CURSOR_ON, BLINK_ON}, 32'h0000_0007);
    chk("mask kept", LINE_SCROLL_MASK, 32'h0000_000A);
    $display("test base bank done");
    host_u.op(cdd_pkg::ADDR_DATA, 1'b1, 8'h41, q);
    host_u.op(cdd_pkg::ADDR_DATA, 1'b1, 8'h42, q);
    ins(8'h8F);
    host_u.op(cdd_pkg::ADDR_DATA, 1'b0, 8'h00, q);
    chk("first byte", q, 32'h0000_0041);
    host_u.op(cdd_pkg::ADDR_DATA, 1'b0, 8'h00, q);
    chk("second byte", q, 32'h0000_0042);
    host_u.op(cdd_pkg::ADDR_INSTR, 1'b0, 8'h00, q);
    chk("counter after reads", q, 32'h0000_0011);
    ins(8'h14);
    host_u.op(cdd_pkg::ADDR_INSTR, 1'b0, 8'h00, q);
    chk("cursor right", q, 32'h0000_0012);
    ins(8'h01);
    host_u.op(cdd_pkg::ADDR_INSTR, 1'b0, 8'h00, q);
    chk("counter after clear", q, 32'h0000_0000);
    $display("test ram access done");
    ins(8'h34);
    ins(8'h35);
    chk("low power", LOW_POWER_ACTIVE, 32'h0000_0001);
    chk("scroll stopped", SCROLL_SHIFT_DOTS, 32'h0000_0000);
    // An extension driver lifts low power, and the scroll then eats one character.
    @(posedge CLK_SYS) EXPANDER_PRESENT <= 1'b1;
    host_u.op(cdd_pkg::ADDR_VIEW, 1'b0, 8'h00, q);
    chk("chars per line", q, 32'h0013_C500);
    chk("expander ends low power", LOW_POWER_ACTIVE, 32'h0000_0000);
    $display("test low power done");
    tally_and_finish();
  end
endmodule : test_char_display_instruction_decoder
`default_nettype wire
